// ==== pkg/crm_pkg.sv ====
// Constants and carriers for the configuration-register message engine.
// Assumes a token link that moves one 9-bit token (control flag + byte) per handshake.
// How it works
// - Low reply byte all ones suppresses write reply
// - Multi-byte fields travel most significant byte first
// - Tile destination pattern selects tile register space
// - Node destination pattern selects node register space
// - Write: token 192, id, reg, data, token 1
// - Read: token 193, id, reg, token 1
// - Write reply: 3,1 on success; 4,1 failure
// - Read reply: 3, data word, 1; or 4,1
package crm_pkg;

  // ---------------------------------------------------------------
  // Tokens and field sizes
  // ---------------------------------------------------------------
  localparam logic [7:0]  CT_WRITE     = 8'h00_C0;   // 192
  localparam logic [7:0]  CT_READ      = 8'h00_C1;   // 193
  localparam logic [7:0]  CT_END       = 8'h00_01;
  localparam logic [7:0]  CT_ACK       = 8'h00_03;
  localparam logic [7:0]  CT_NACK      = 8'h00_04;
  localparam logic [7:0]  NO_REPLY_LOW = 8'h00_FF;
  localparam int          ID_BYTES     = 3;
  localparam int          REG_BYTES    = 2;
  localparam int          DATA_BYTES   = 4;
  localparam int          ACC_WAIT     = 1;   // Extra cycles until the bank answers
  localparam logic [7:0]  PS_RES_TYPE  = 8'h00_0B;
  localparam int          PS_SHIFT     = 8;
  // Low 16 bits of a destination resource id
  localparam logic [15:0] DEST_TILE_LO = 16'hC2_0C;
  localparam logic [15:0] DEST_NODE_LO = 16'hC3_0C;

  typedef struct packed {
    logic       ctrl;   // control token when set
    logic [7:0] val;
  } crm_tok_t;

  typedef struct packed {
    logic        wr;     // write when set
    logic        node;   // node space when set, tile space otherwise
    logic [15:0] num;
    logic [31:0] data;
  } crm_acc_t;

  // Processor-status resource id for a register number
  function automatic logic [31:0] crm_ps_resid(input logic [15:0] num);
    crm_ps_resid = ({16'h0000, num} << PS_SHIFT) | {24'h00_0000, PS_RES_TYPE};
  endfunction : crm_ps_resid

endpackage : crm_pkg

// ==== rtl/crm_shift.sv ====
// Byte-serial shift register: loads bytes MSB first, unloads MSB first.
// Assumes caller never shifts and loads in one cycle.
module crm_shift #(
  parameter int W = 32
) (
  input  wire logic         clock,     // System clock
  input  wire logic         rst,       // Sync reset, high
  input  wire logic         shift_in,  // Push byte in at LSB end
  input  wire logic [7:0]   byte_in,   // Byte pushed in
  input  wire logic         load,      // Parallel load
  input  wire logic [W-1:0] load_val,  // Parallel value
  input  wire logic         shift_out, // Drop top byte
  output logic      [W-1:0] value,     // Current content
  output logic      [7:0]   top_byte   // Next byte out
);
  logic [W-1:0] sr_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      sr_reg <= '0;
    end else if (load) begin
      sr_reg <= load_val;
    end else if (shift_in) begin
      sr_reg <= {sr_reg[W-9:0], byte_in};
    end else if (shift_out) begin
      sr_reg <= {sr_reg[W-9:0], 8'h00};
    end
  end

  assign value    = sr_reg;
  assign top_byte = sr_reg[W-1 -: 8];
endmodule : crm_shift

// ==== rtl/crm_engine.sv ====
// Configuration-register message engine: parses requests, runs one register
// access, emits the reply. Assumes the register bank answers acc_ok/acc_rdata
// in the cycle after acc_req, and that the network routes only messages whose
// destination low half matches one of our two patterns.
module crm_engine #(
  parameter logic [15:0] NODE_ID = 16'h0000  // Arbitrary default identifier
) (
  input  wire logic                 clock,       // System clock
  input  wire logic                 rst,         // Sync reset, high
  input  wire logic [15:0]          rx_dest_lo,  // Low destination bits of message
  input  wire logic                 rx_valid,    // Inbound token valid
  input  wire crm_pkg::crm_tok_t    rx_tok,      // Inbound token
  output logic                      rx_ready,    // Inbound token taken
  output logic                      tx_valid,    // Outbound token valid
  output crm_pkg::crm_tok_t         tx_tok,      // Outbound token
  output logic [23:0]               tx_dest,     // Reply channel-end id
  input  wire logic                 tx_ready,    // Outbound token accepted
  output logic                      acc_req,     // Register access pulse
  output crm_pkg::crm_acc_t         acc,         // Access details
  input  wire logic                 acc_ok,      // Access succeeded
  input  wire logic [31:0]          acc_rdata    // Read data
);
  import crm_pkg::*;

  // ---------------------------------------------------------------
  // Parser state
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    S_IDLE = 9'b000000001,
    S_ID   = 9'b000000010,
    S_REG  = 9'b000000100,
    S_DATA = 9'b000001000,
    S_END  = 9'b000010000,
    S_ACC  = 9'b000100000,
    S_HEAD = 9'b001000000,
    S_BODY = 9'b010000000,
    S_TAIL = 9'b100000000
  } crm_state_t;

  crm_state_t  st_reg;
  logic [2:0]  cnt_reg;
  logic        wr_reg;
  logic        node_reg;
  logic        ok_reg;
  logic        bad_reg;   // malformed request, answer with failure; set but unanswered when cut short in the id field
  logic [23:0] id_reg;
  logic [15:0] num_reg;
  logic [31:0] data_val;
  logic [7:0]  data_top;
  logic        take;
  logic        send;
  logic        is_data;

  // Requests are taken only while parsing; reply holds off the next one
  assign rx_ready = st_reg inside {S_IDLE, S_ID, S_REG, S_DATA, S_END};
  assign take     = rx_valid && rx_ready;
  assign send     = tx_valid && tx_ready;
  assign is_data  = take && !rx_tok.ctrl;

  // ---------------------------------------------------------------
  // Sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg  <= S_IDLE;
      cnt_reg <= 3'd0;
      bad_reg <= 1'b0;
    end else begin
      case (st_reg)
        S_IDLE: if (take && rx_tok.ctrl &&
                    (rx_tok.val == CT_WRITE || rx_tok.val == CT_READ) &&
                    (rx_dest_lo == DEST_TILE_LO ||
                     rx_dest_lo == DEST_NODE_LO)) begin
          st_reg  <= S_ID;
          cnt_reg <= 3'(ID_BYTES - 1);
          bad_reg <= 1'b0;
        end
        S_ID: if (take) begin
          if (rx_tok.ctrl) begin
            bad_reg <= 1'b1;
            st_reg  <= S_IDLE;   // no reply id yet, nowhere to answer
          end else if (cnt_reg == 3'd0) begin
            st_reg  <= S_REG;
            cnt_reg <= 3'(REG_BYTES - 1);
          end else begin
            cnt_reg <= cnt_reg - 3'd1;
          end
        end
        S_REG: if (take) begin
          if (rx_tok.ctrl) begin
            bad_reg <= 1'b1;
            st_reg  <= S_ACC;
            cnt_reg <= 3'(ACC_WAIT);
          end else if (cnt_reg == 3'd0) begin
            st_reg  <= wr_reg ? S_DATA : S_END;
            cnt_reg <= 3'(DATA_BYTES - 1);
          end else begin
            cnt_reg <= cnt_reg - 3'd1;
          end
        end
        S_DATA: if (take) begin
          if (rx_tok.ctrl) begin
            bad_reg <= 1'b1;
            st_reg  <= S_ACC;
            cnt_reg <= 3'(ACC_WAIT);
          end else if (cnt_reg == 3'd0) begin
            st_reg <= S_END;
          end else begin
            cnt_reg <= cnt_reg - 3'd1;
          end
        end
        S_END: if (take) begin
          if (!(rx_tok.ctrl && rx_tok.val == CT_END)) begin
            bad_reg <= 1'b1;
          end
          st_reg  <= S_ACC;
          cnt_reg <= 3'(ACC_WAIT);
        end
        // Bank answers the cycle after acc_req, so wait here until it has
        S_ACC: if (cnt_reg == 3'd0) begin
          st_reg <= S_HEAD;
        end else begin
          cnt_reg <= cnt_reg - 3'd1;
        end
        S_HEAD: if (wr_reg && id_reg[7:0] == NO_REPLY_LOW) begin
          st_reg <= S_IDLE;
        end else if (send) begin
          st_reg  <= (!wr_reg && ok_reg) ? S_BODY : S_TAIL;
          cnt_reg <= 3'(DATA_BYTES - 1);
        end
        S_BODY: if (send) begin
          if (cnt_reg == 3'd0) begin
            st_reg <= S_TAIL;
          end else begin
            cnt_reg <= cnt_reg - 3'd1;
          end
        end
        S_TAIL: if (send) begin
          st_reg <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Captured fields
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      wr_reg   <= 1'b0;
      node_reg <= 1'b0;
      id_reg   <= '0;
      num_reg  <= '0;
    end else begin
      if (st_reg == S_IDLE && take) begin
        wr_reg   <= (rx_tok.val == CT_WRITE);
        node_reg <= (rx_dest_lo == DEST_NODE_LO);
      end
      if (st_reg == S_ID && is_data) begin
        id_reg <= {id_reg[15:0], rx_tok.val};
      end
      if (st_reg == S_REG && is_data) begin
        num_reg <= {num_reg[7:0], rx_tok.val};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ok_reg <= 1'b0;
    end else if (st_reg == S_ACC && cnt_reg == 3'd0) begin
      ok_reg <= acc_ok && !bad_reg;
    end
  end

  // Data word: filled from the link on writes, loaded with read data after access
  crm_shift #(.W(32)) u_data (
    .clock     (clock),
    .rst       (rst),
    .shift_in  (st_reg == S_DATA && is_data),
    .byte_in   (rx_tok.val),
    .load      (st_reg == S_ACC && cnt_reg == 3'd0 && !wr_reg),
    .load_val  (acc_rdata),
    .shift_out (st_reg == S_BODY && send),
    .value     (data_val),
    .top_byte  (data_top)
  );

  // Access fires once per request, skipped if malformed
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_req <= 1'b0;
      acc     <= '0;
    end else begin
      acc_req <= 1'b0;
      if (st_reg == S_END && take && rx_tok.ctrl && rx_tok.val == CT_END && !bad_reg) begin
        acc_req <= 1'b1;
      end
      acc <= '{wr: wr_reg, node: node_reg, num: num_reg, data: data_val};
    end
  end

  // ---------------------------------------------------------------
  // Reply
  // ---------------------------------------------------------------
  assign tx_dest  = id_reg;
  assign tx_valid = (st_reg == S_HEAD && !(wr_reg && id_reg[7:0] == NO_REPLY_LOW)) ||
                    st_reg == S_BODY || st_reg == S_TAIL;

  always_comb begin
    tx_tok = '{ctrl: 1'b1, val: CT_END};
    case (st_reg)
      S_HEAD:  tx_tok = '{ctrl: 1'b1, val: ok_reg ? CT_ACK : CT_NACK};
      S_BODY:  tx_tok = '{ctrl: 1'b0, val: data_top};
      default: tx_tok = '{ctrl: 1'b1, val: CT_END};
    endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_no_reply_quiet: assert property (@(posedge clock) disable iff (rst)
    (st_reg == S_ACC && wr_reg && id_reg[7:0] == NO_REPLY_LOW) |=> !tx_valid [*2])
    else $error("reply sent for suppressed write");
  a_busy_blocks: assert property (@(posedge clock) disable iff (rst)
    tx_valid |-> !rx_ready)
    else $error("request taken while replying");
  a_head_token: assert property (@(posedge clock) disable iff (rst)
    (st_reg == S_HEAD && tx_valid) |-> tx_tok.ctrl &&
      (tx_tok.val == ((ok_reg && !bad_reg) ? CT_ACK : CT_NACK)))
    else $error("bad head token");
  a_read_body: assert property (@(posedge clock) disable iff (rst)
    (st_reg == S_HEAD && send && !wr_reg && ok_reg) |=> st_reg == S_BODY && !tx_tok.ctrl)
    else $error("read data missing");
  a_fail_short: assert property (@(posedge clock) disable iff (rst)
    (st_reg == S_HEAD && send && !ok_reg) |=> st_reg == S_TAIL && tx_tok.val == CT_END)
    else $error("failure reply too long");
  a_access_once: assert property (@(posedge clock) disable iff (rst)
    acc_req |=> !acc_req ##1 st_reg == S_HEAD)
    else $error("access not single");
  a_acc_after: assert property (@(posedge clock) disable iff (rst)
    (st_reg == S_END && take && rx_tok.ctrl && rx_tok.val == CT_END && !bad_reg) |=> acc_req)
    else $error("access not issued");
  a_id_shift: assert property (@(posedge clock) disable iff (rst)
    (st_reg == S_ID && is_data) |=> id_reg[7:0] == $past(rx_tok.val))
    else $error("id byte order");
  a_dest_match: assert property (@(posedge clock) disable iff (rst)
    (st_reg == S_IDLE && take && rx_dest_lo != DEST_TILE_LO &&
     rx_dest_lo != DEST_NODE_LO) |=> st_reg == S_IDLE)
    else $error("foreign destination accepted");
  a_node_space: assert property (@(posedge clock) disable iff (rst)
    (st_reg == S_IDLE && take && rx_dest_lo == DEST_NODE_LO) |=> node_reg)
    else $error("node space not marked");

endmodule : crm_engine

// ==== tb/crm_req_model.sv ====
// Requesting channel-end model: sends framed requests, takes reply tokens.
// Assumes the engine samples both handshakes at the rising clock edge.
module crm_req_model
  import crm_pkg::*;
(
  input  wire logic              clock,      // System clock
  input  wire logic              rx_ready,   // Engine takes token
  output logic                   rx_valid,   // Token offered
  output crm_pkg::crm_tok_t      rx_tok,     // Token offered
  output logic [15:0]            rx_dest_lo, // Destination low half
  input  wire logic              tx_valid,   // Reply token valid
  input  wire crm_pkg::crm_tok_t tx_tok,     // Reply token
  output logic                   tx_ready    // Reply token taken
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_valid   = 1'b0;
    rx_tok     = '0;
    rx_dest_lo = 16'h0000;
    tx_ready   = 1'b0;
  end

  // -------------------------------------------------------------
  // Request side
  // -------------------------------------------------------------
  // Offer is held until the edge that sees rx_ready high
  task put(input logic c, input logic [7:0] v);
    rx_valid <= 1'b1;
    rx_tok   <= '{ctrl: c, val: v};
    @(posedge clock iff rx_ready);
  endtask : put

  task put_bytes(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      put(1'b0, v[8*i +: 8]);
    end
  endtask : put_bytes

  task msg(input logic wr, input logic node, input logic [23:0] id,
           input logic [15:0] num, input logic [31:0] data);
    rx_dest_lo <= node ? DEST_NODE_LO : DEST_TILE_LO;
    put(1'b1, wr ? CT_WRITE : CT_READ);
    put_bytes({8'h00, id}, ID_BYTES);
    put_bytes({16'h0000, num}, REG_BYTES);
    if (wr) begin
      put_bytes(data, DATA_BYTES);
    end
    put(1'b1, CT_END);
    drop();
  endtask : msg

  // Released lines show the inverse, so no stale token can pass
  task drop();
    rx_valid <= 1'b0;
    rx_tok   <= ~rx_tok;
  endtask : drop

  // -------------------------------------------------------------
  // Reply side
  // -------------------------------------------------------------
  task get(output crm_tok_t t, input int stall);
    if (stall > 0) begin
      tx_ready <= 1'b0;
      repeat (stall) @(posedge clock);
    end
    tx_ready <= 1'b1;
    @(posedge clock iff (tx_valid && tx_ready));
    t = tx_tok;
  endtask : get

  task idle();
    tx_ready <= 1'b0;
  endtask : idle
endmodule : crm_req_model

// ==== tb/config_register_message_access_tb_top.sv ====
// Testbench for the configuration-register message engine.
// Assumes a register bank of 16 words that answers the cycle after acc_req.
module config_register_message_access_tb_top;
  import crm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock;
  logic        rst;
  logic [15:0] rx_dest_lo;
  logic        rx_valid;
  crm_tok_t    rx_tok;
  logic        rx_ready;
  logic        tx_valid;
  crm_tok_t    tx_tok;
  logic [23:0] tx_dest;
  logic        tx_ready;
  logic        acc_req;
  crm_acc_t    acc;
  logic        acc_ok;
  logic [31:0] acc_rdata;
  logic [31:0] mem [16];
  logic        last_node;
  logic [31:0] acc_seen;
  int          fail_count;
  int          tests_run;
  int          cycles;

  crm_engine i_dut (.clock(clock), .rst(rst), .rx_dest_lo(rx_dest_lo), .rx_valid(rx_valid),
    .rx_tok(rx_tok), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_tok(tx_tok),
    .tx_dest(tx_dest), .tx_ready(tx_ready), .acc_req(acc_req), .acc(acc),
    .acc_ok(acc_ok), .acc_rdata(acc_rdata));

  crm_req_model i_req (.clock(clock), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_tok(rx_tok), .rx_dest_lo(rx_dest_lo), .tx_valid(tx_valid), .tx_tok(tx_tok),
    .tx_ready(tx_ready));

  // -------------------------------------------------------------
  // Register bank: numbers above 15 fail
  // -------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      acc_ok    <= 1'b0;
      acc_rdata <= 32'h0000_0000;
      last_node <= 1'b0;
      acc_seen  <= 32'h0000_0000;
    end else begin
      acc_ok    <= acc_req && (acc.num < 16'h0010);
      acc_rdata <= mem[acc.num[3:0]];
      if (acc_req) begin
        acc_seen  <= acc_seen + 32'h0000_0001;
        last_node <= acc.node;
        if (acc.wr && acc.num < 16'h0010) begin
          mem[acc.num[3:0]] <= acc.data;
        end
      end
    end
  end

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // -------------------------------------------------------------
  // Checking helpers
  // -------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task reply(input logic ok, input logic rd, input logic [31:0] d,
             input logic [23:0] id, input int stall);
    crm_tok_t t;
    i_req.get(t, stall);
    chk("reply head", {23'h0, 1'b1, ok ? CT_ACK : CT_NACK}, {23'h0, t});
    chk("reply dest", {8'h00, id}, {8'h00, tx_dest});
    if (ok && rd) begin
      for (int i = 3; i >= 0; i--) begin
        i_req.get(t, stall);
        chk("read byte", {23'h0, 1'b0, d[8*i +: 8]}, {23'h0, t});
      end
    end
    i_req.get(t, stall);
    chk("reply end", {23'h0, 1'b1, CT_END}, {23'h0, t});
    i_req.idle();
  endtask : reply

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task t_rw();
    i_req.msg(1'b1, 1'b0, 24'h12_3456, 16'h0005, 32'hA5B6_C7D8);
    reply(1'b1, 1'b0, 32'h0, 24'h12_3456, 0);
    chk("tile flag", 32'h0, {31'h0, last_node});
    chk("status id", 32'h0000_050B, crm_ps_resid(16'h0005));
    i_req.msg(1'b0, 1'b0, 24'h12_3456, 16'h0005, 32'h0);
    reply(1'b1, 1'b1, 32'hA5B6_C7D8, 24'h12_3456, 3);
  endtask : t_rw

  task t_fail();
    i_req.msg(1'b0, 1'b1, 24'hAB_CD01, 16'h0100, 32'h0);
    reply(1'b0, 1'b1, 32'h0, 24'hAB_CD01, 0);
    chk("node flag", 32'h1, {31'h0, last_node});
    i_req.msg(1'b1, 1'b1, 24'hAB_CD01, 16'h0100, 32'h1234_5678);
    reply(1'b0, 1'b0, 32'h0, 24'hAB_CD01, 2);
  endtask : t_fail

  // Silent write straight into a read: first reply must be the read's
  task t_quiet();
    i_req.msg(1'b1, 1'b0, 24'h12_34FF, 16'h0007, 32'h0102_0304);
    i_req.msg(1'b0, 1'b1, 24'h00_0102, 16'h0007, 32'h0);
    reply(1'b1, 1'b1, 32'h0102_0304, 24'h00_0102, 0);
  endtask : t_quiet

  // Read cut short by an end token in the register field: refused, no access
  task t_bad();
    logic [31:0] n;
    n = acc_seen;
    i_req.rx_dest_lo <= DEST_TILE_LO;
    i_req.put(1'b1, CT_READ);
    i_req.put_bytes({8'h00, 24'h00_0203}, ID_BYTES);
    i_req.put(1'b1, CT_END);
    i_req.drop();
    reply(1'b0, 1'b1, 32'h0, 24'h00_0203, 0);
    chk("access count", n, acc_seen);
  endtask : t_bad

  // -------------------------------------------------------------
  // Run control
  // -------------------------------------------------------------
  task wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    rst        = 1'b1;
    fail_count = 0;
    tests_run  = 0;
    cycles     = 0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_rw();
    t_fail();
    t_quiet();
    t_bad();
    wrap_up();
  end
endmodule : config_register_message_access_tb_top
